/* File: rtl/irx_defines.svh */
// Timing constants for the infrared transceiver mode controller
`ifndef IRX_DEFINES_SVH
`define IRX_DEFINES_SVH
`define IRX_CLK_PERIOD_PS 25000
`define IRX_SETUP_NS 200
`define IRX_SPEED_SETUP_NS 50
`define IRX_HOLD_NS 50
`define IRX_RC_PULSE_NS 200
`define IRX_PROG_MAX_NS 5000
`define IRX_SHUT_MIN_US 30
// Least times round up, longest times round down
`define IRX_CYC_UP(ns) (((ns) * 1000 + `IRX_CLK_PERIOD_PS - 1) / `IRX_CLK_PERIOD_PS)
`define IRX_CYC_DN(ns) (((ns) * 1000) / `IRX_CLK_PERIOD_PS)
`define IRX_SETUP_CYC `IRX_CYC_UP(`IRX_SETUP_NS)
`define IRX_SPEED_SETUP_CYC `IRX_CYC_UP(`IRX_SPEED_SETUP_NS)
`define IRX_HOLD_CYC `IRX_CYC_UP(`IRX_HOLD_NS)
`define IRX_RC_PULSE_CYC `IRX_CYC_UP(`IRX_RC_PULSE_NS)
`define IRX_PROG_MAX_CYC `IRX_CYC_DN(`IRX_PROG_MAX_NS)
`define IRX_SHUT_MIN_CYC `IRX_CYC_UP(`IRX_SHUT_MIN_US * 1000)
`endif

/* File: rtl/irx_pkg.sv */
// Types for the infrared transceiver mode controller
package irx_pkg;
  // Requested operation
  typedef enum logic [2:0] {
    IRX_CMD_SIR = 3'h0,
    IRX_CMD_FIR = 3'h1,
    IRX_CMD_RC = 3'h2,
    IRX_CMD_SHUT = 3'h3,
    IRX_CMD_WAKE = 3'h4
  } irx_cmd_type;
  // Latched mode as the controller tracks it
  typedef enum logic [1:0] {
    IRX_MODE_SIR = 2'h0,
    IRX_MODE_FIR = 2'h1,
    IRX_MODE_RC = 2'h2
  } irx_mode_type;
endpackage

/* File: rtl/irx_tmr_if.sv */
// Interface between the sequencer and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface irx_tmr_if #(parameter int CW = 16);
  logic load;
  logic [CW-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

/* File: rtl/irx_timer.sv */
// Down-counting interval timer used by the sequencer
`timescale 1ns/1ps
`default_nettype none
module irx_timer #(parameter int CW = 16) (
  input wire logic ref_clk,
  input wire logic rstn,
  irx_tmr_if.tmr t
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  // Next count: reload, count down, or hold at zero
  assign cnt_nxt = t.load ? t.count : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign run_nxt = t.load ? 1'b1 : (run_r && (cnt_r > CW'(1)));
  assign t.done = run_r && (cnt_r <= CW'(1));
  // ************
  // Counter
  // ************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/irx_ctrl.sv */
// Host controller that programs and drives the infrared transceiver pins
// How it works
// [RULE1] Device powers up in SIR; tracked mode starts at SIR.
// [RULE2] Single-input mode: all data leaves on ir_tx_in by latched mode.
// [RULE3] Controller runs a programming sequence to pick infrared or remote mode.
// [RULE4] Dual-input mode: infrared data on ir_tx_in, remote data on rc_tx_in.
// [RULE5] Shutdown low: one transmit input high at most; never both.
// [RULE6] Shutdown high, inputs low turns LED off and resets mode to SIR.
// [RULE7] Shutdown high at least 30 us gives complete shutdown.
// [RULE8] Programming pulse stays at most 5.0 us and above setup plus remote pulse.
// [RULE9] Fast mode: shutdown high, wait 200 ns, ir high, 50 ns, drop, hold 50 ns.
// [RULE10] Device latches ir_tx_in level at shutdown falling edge as speed.
// [RULE11] SIR: shutdown high, ir low 50 ns, drop shutdown, keep low 50 ns.
// [RULE12] After hold, ir_tx_in again carries normal infrared data.
// [RULE13] Remote mode: ir_tx_in pulse of at least 200 ns inside programming pulse.
// [RULE14] Hold ir_tx_in and shutdown stable 50 ns after the latching edge.
// [RULE15] If io_supply precedes core supply, drive shutdown high.
// [RULE16] Minimum times round up, maximum times round down to cycles.
`timescale 1ns/1ps
`default_nettype none
`include "irx_defines.svh"
module irx_ctrl #(
  parameter int CW = 16,
  parameter int SHUT_CYC = `IRX_SHUT_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dual_input,
  input wire logic cmd_valid,
  input wire irx_pkg::irx_cmd_type cmd,
  output logic cmd_ready,
  input wire logic ir_data,
  input wire logic rc_data,
  input wire logic io_supply_early,
  output logic shutdown_ctrl,
  output logic ir_tx_in,
  output logic rc_tx_in,
  output irx_pkg::irx_mode_type mode,
  output logic asleep
);
  // ************
  // Sequencer states
  // ************
  typedef enum logic [2:0] {
    IRX_ST_IDLE = 3'h0,
    IRX_ST_SETUP = 3'h1,
    IRX_ST_RCP = 3'h2,
    IRX_ST_SPD = 3'h3,
    IRX_ST_HOLD = 3'h4,
    IRX_ST_SHUT = 3'h5,
    IRX_ST_OFF = 3'h6
  } irx_st_type;

  irx_st_type st_r;
  irx_st_type st_nxt;
  irx_pkg::irx_mode_type mode_r;
  irx_pkg::irx_mode_type mode_nxt;
  irx_pkg::irx_cmd_type cmd_r;
  logic sd_r;
  logic sd_nxt;
  logic ir_r;
  logic ir_nxt;
  logic rc_r;
  logic rc_nxt;
  logic rdy_r;
  logic [2:0] io_sync_r;
  logic io_early;
  logic accept;
  logic dn;
  logic [CW-1:0] ld_cnt;
  logic ld;
  logic [CW-1:0] prog_cnt_r;
  logic io_early_r;
  logic prog_run;

  irx_tmr_if #(.CW(CW)) tif ();
  irx_timer #(.CW(CW)) u_tmr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .t(tif)
  );
  assign tif.load = ld;
  assign tif.count = ld_cnt;
  assign dn = tif.done;

  // Supply-order strap: three stages, a change counts once the last two agree
  assign io_early = io_early_r;
  assign accept = cmd_valid && rdy_r;

  // ************
  // Next-state logic
  // ************
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    sd_nxt = sd_r;
    ld = 1'b0;
    ld_cnt = '0;
    case (st_r)
      IRX_ST_IDLE: begin
        if (io_early) begin
          sd_nxt = 1'b1; // RULE15
        end else if (accept) begin
          sd_nxt = 1'b1; // RULE3
          ld = 1'b1;
          if (cmd == irx_pkg::IRX_CMD_SHUT) begin
            ld_cnt = CW'(SHUT_CYC); // RULE7
            st_nxt = IRX_ST_SHUT;
          end else if (cmd == irx_pkg::IRX_CMD_WAKE) begin
            sd_nxt = 1'b0;
            ld = 1'b0;
          end else begin
            ld_cnt = CW'(`IRX_SETUP_CYC); // RULE9 RULE16
            st_nxt = IRX_ST_SETUP;
          end
        end else begin
          sd_nxt = asleep;
        end
      end
      IRX_ST_SETUP: if (dn) begin
        ld = 1'b1;
        if (cmd_r == irx_pkg::IRX_CMD_RC) begin
          ld_cnt = CW'(`IRX_RC_PULSE_CYC); // RULE13
          st_nxt = IRX_ST_RCP;
        end else begin
          ld_cnt = CW'(`IRX_SPEED_SETUP_CYC); // RULE11
          st_nxt = IRX_ST_SPD;
        end
      end
      IRX_ST_RCP: if (dn) begin
        ld = 1'b1;
        ld_cnt = CW'(`IRX_SPEED_SETUP_CYC);
        st_nxt = IRX_ST_SPD;
      end
      IRX_ST_SPD: if (dn) begin
        sd_nxt = 1'b0; // RULE8 RULE10
        ld = 1'b1;
        ld_cnt = CW'(`IRX_HOLD_CYC); // RULE14
        st_nxt = IRX_ST_HOLD;
      end
      IRX_ST_HOLD: if (dn) begin
        st_nxt = IRX_ST_IDLE; // RULE12
        case (cmd_r)
          irx_pkg::IRX_CMD_FIR: mode_nxt = irx_pkg::IRX_MODE_FIR;
          irx_pkg::IRX_CMD_RC: mode_nxt = irx_pkg::IRX_MODE_RC;
          default: mode_nxt = irx_pkg::IRX_MODE_SIR;
        endcase
      end
      IRX_ST_SHUT: if (dn) begin
        mode_nxt = irx_pkg::IRX_MODE_SIR; // RULE6
        st_nxt = IRX_ST_OFF;
      end
      IRX_ST_OFF: st_nxt = IRX_ST_IDLE;
      default: st_nxt = IRX_ST_IDLE;
    endcase
    // Early I/O supply keeps shutdown high whatever the sequencer does
    if (io_early) begin
      sd_nxt = 1'b1; // RULE15
    end
  end

  // Transmit pin levels for the coming state, so ir edges move with the state
  always_comb begin
    ir_nxt = 1'b0;
    rc_nxt = 1'b0;
    case (st_nxt)
      IRX_ST_IDLE: begin
        if (!sd_nxt && !asleep && !io_early) begin
          if (dual_input) begin
            ir_nxt = ir_data; // RULE4
            rc_nxt = rc_data & ~ir_data; // RULE5
          end else begin
            ir_nxt = (mode_nxt == irx_pkg::IRX_MODE_RC) ? rc_data : ir_data; // RULE2
          end
        end
      end
      IRX_ST_RCP: ir_nxt = 1'b1; // RULE13
      IRX_ST_SPD: ir_nxt = (cmd_r == irx_pkg::IRX_CMD_FIR); // RULE9
      IRX_ST_HOLD: ir_nxt = (cmd_r == irx_pkg::IRX_CMD_FIR); // RULE14
      default: begin
        ir_nxt = 1'b0; // RULE6
        rc_nxt = 1'b0;
      end
    endcase
  end

  // ************
  // Registers
  // ************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= IRX_ST_IDLE;
      mode_r <= irx_pkg::IRX_MODE_SIR; // RULE1
      cmd_r <= irx_pkg::IRX_CMD_SIR;
      sd_r <= 1'b0;
      ir_r <= 1'b0;
      rc_r <= 1'b0;
      rdy_r <= 1'b0;
      asleep <= 1'b0;
      io_sync_r <= 3'h0;
      io_early_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      sd_r <= sd_nxt;
      ir_r <= ir_nxt;
      rc_r <= rc_nxt;
      io_sync_r <= {io_sync_r[1:0], io_supply_early};
      if (io_sync_r[2] == io_sync_r[1]) begin
        io_early_r <= io_sync_r[2]; // RULE15
      end
      rdy_r <= (st_nxt == IRX_ST_IDLE) && !accept && !io_early;
      if (accept) begin
        cmd_r <= cmd;
      end
      if (st_r == IRX_ST_OFF) begin
        asleep <= 1'b1;
      end else if (accept && cmd == irx_pkg::IRX_CMD_WAKE) begin
        asleep <= 1'b0;
      end
    end
  end

  // Length of the current shutdown-high pulse, shutdown pulse included until asleep is set; strap pulses do not count
  assign prog_run = sd_r && !asleep && !io_early;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prog_cnt_r <= '0;
    end else begin
      prog_cnt_r <= prog_run ? ((prog_cnt_r != '1) ? prog_cnt_r + 1'b1 : prog_cnt_r) : '0;
    end
  end

  assign shutdown_ctrl = sd_r;
  assign ir_tx_in = ir_r;
  assign rc_tx_in = rc_r;
  assign mode = mode_r;
  assign cmd_ready = rdy_r;

  // ************
  // Assertions
  // ************
  never_both_tx_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE5
    !(ir_tx_in && rc_tx_in)) else $error("both transmit inputs high");
  prog_pulse_max_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE8
    (st_r != IRX_ST_SHUT && st_r != IRX_ST_OFF && !asleep && !io_early)
    |-> prog_cnt_r <= CW'(`IRX_PROG_MAX_CYC)) else $error("programming pulse too long");
  setup_wait_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE9
    $rose(shutdown_ctrl) && !io_early |-> !ir_tx_in [*8]) else $error("setup too short");
  hold_after_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE14
    $fell(shutdown_ctrl) && $past(ir_tx_in) |-> ir_tx_in [*2]) else $error("hold broken");
  mode_update_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE10
    st_r == IRX_ST_HOLD && dn && cmd_r == irx_pkg::IRX_CMD_FIR
    |=> mode == irx_pkg::IRX_MODE_FIR) else $error("mode not latched");
  shut_sir_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE6
    st_r == IRX_ST_OFF |-> mode == irx_pkg::IRX_MODE_SIR && shutdown_ctrl) else $error("shut mode");
  rc_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE13
    $rose(ir_tx_in) && shutdown_ctrl && cmd_r == irx_pkg::IRX_CMD_RC |-> ir_tx_in [*8])
    else $error("remote pulse short");
  idle_sd_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE15
    io_early |-> ##1 shutdown_ctrl) else $error("shutdown not raised");
  fir_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
    accept && cmd == irx_pkg::IRX_CMD_FIR ##[1:40] mode == irx_pkg::IRX_MODE_FIR);
  rc_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
    accept && cmd == irx_pkg::IRX_CMD_RC ##[1:40] mode == irx_pkg::IRX_MODE_RC);
  shut_cov: cover property (@(posedge ref_clk) disable iff (!rstn) st_r == IRX_ST_OFF);
endmodule
`default_nettype wire

/* File: sim/irx_dev_model.sv */
// Behavioural model of the transceiver mode logic
`timescale 1ns/1ps
`default_nettype none
module irx_dev_model #(
  parameter realtime SHUT_NS = 30000.0
) (
  input wire logic shutdown_ctrl,
  input wire logic ir_tx_in,
  input wire logic rc_tx_in,
  output logic [1:0] dev_mode,
  output logic led,
  output logic viol
);
  realtime sd_rise = 0.0;
  realtime sd_fall = -1000.0;
  realtime ir_rise = 0.0;
  realtime ir_edge = 0.0;
  logic rc_seen = 1'b0;
  logic off = 1'b0;
  initial dev_mode = 2'h0;
  initial viol = 1'b0;
  // LED from the pin truth table
  assign led = !off && !shutdown_ctrl && (ir_tx_in ^ rc_tx_in);
  // Transmit pin edges and remote pulse width
  always @(ir_tx_in) begin
    if ($realtime > 0.0 && $realtime - sd_fall < 50.0)
      viol = 1'b1;
    if (ir_tx_in)
      ir_rise = $realtime;
    else if (shutdown_ctrl && $realtime - ir_rise >= 200.0)
      rc_seen = 1'b1;
    ir_edge = $realtime;
  end
  // Pulse start; a long pulse gives complete shutdown and default mode
  always begin
    @(posedge shutdown_ctrl);
    sd_rise = $realtime;
    rc_seen = 1'b0;
    while (shutdown_ctrl && $realtime - sd_rise < SHUT_NS)
      #1;
    if (shutdown_ctrl) begin
      off = 1'b1;
      dev_mode = 2'h0;
    end
  end
  // Falling edge latches speed or remote selection
  always @(negedge shutdown_ctrl) begin
    if ($realtime > 0.0 && !off) begin
      if ($realtime - sd_rise > 5000.0 || $realtime - ir_edge < 50.0)
        viol = 1'b1;
      dev_mode = rc_seen ? 2'h2 : {1'b0, ir_tx_in};
    end
    off = 1'b0;
    sd_fall = $realtime;
  end
endmodule
`default_nettype wire

/* File: sim/ir_transceiver_mode_programming_test.sv */
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_mode_programming_test;
  localparam int SHUT_CYC = 40;
  logic ref_clk = 1'b0;
  logic rstn;
  logic dual_input = 1'b0;
  logic cmd_valid = 1'b0;
  irx_pkg::irx_cmd_type cmd = irx_pkg::IRX_CMD_SIR;
  logic ir_data = 1'b0;
  logic rc_data = 1'b0;
  logic io_supply_early = 1'b0;
  logic cmd_ready, shutdown_ctrl, ir_tx_in, rc_tx_in, asleep, led, viol;
  irx_pkg::irx_mode_type mode;
  logic [1:0] dev_mode;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  irx_ctrl #(.SHUT_CYC(SHUT_CYC)) DUT (.ref_clk(ref_clk), .rstn(rstn),
    .dual_input(dual_input), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .ir_data(ir_data), .rc_data(rc_data), .io_supply_early(io_supply_early),
    .shutdown_ctrl(shutdown_ctrl), .ir_tx_in(ir_tx_in), .rc_tx_in(rc_tx_in),
    .mode(mode), .asleep(asleep));
  irx_dev_model #(.SHUT_NS(SHUT_CYC * 25.0)) dev (.shutdown_ctrl(shutdown_ctrl),
    .ir_tx_in(ir_tx_in), .rc_tx_in(rc_tx_in), .dev_mode(dev_mode), .led(led), .viol(viol));
  // Clock and hang guard
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request, then wait for the controller to be idle again
  task automatic run_cmd(input irx_pkg::irx_cmd_type c);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < SHUT_CYC + 100);
    #1;
  endtask
  task automatic prog(input irx_pkg::irx_cmd_type c, input logic [1:0] m);
    run_cmd(c);
    chk("mode", m, mode);
    chk("dev mode", m, dev_mode);
    chk("sd idle", 2'h0, {1'b0, shutdown_ctrl});
  endtask
  // Data levels in, pins and LED out
  task automatic send(input logic i, input logic r, input logic [1:0] pins, input logic l);
    @(posedge ref_clk);
    ir_data <= i;
    rc_data <= r;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("tx pins", pins, {ir_tx_in, rc_tx_in});
    chk("led", {1'b0, l}, {1'b0, led});
  endtask
  task automatic t_shut();
    run_cmd(irx_pkg::IRX_CMD_SHUT);
    chk("asleep", 2'h1, {1'b0, asleep});
    chk("mode", 2'h0, mode);
    chk("dev mode", 2'h0, dev_mode);
    chk("sd held", 2'h1, {1'b0, shutdown_ctrl});
    run_cmd(irx_pkg::IRX_CMD_WAKE);
    chk("awake", 2'h0, {asleep, shutdown_ctrl});
  endtask
  task automatic t_supply();
    @(posedge ref_clk);
    io_supply_early <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("sd early", 2'h1, {1'b0, shutdown_ctrl});
    @(posedge ref_clk);
    io_supply_early <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("sd late", 2'h0, {1'b0, shutdown_ctrl});
  endtask
  // Main sequence
  initial begin
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("mode", 2'h0, mode);
    chk("ready", 2'h1, {1'b0, cmd_ready});
    prog(irx_pkg::IRX_CMD_FIR, 2'h1);
    prog(irx_pkg::IRX_CMD_SIR, 2'h0);
    prog(irx_pkg::IRX_CMD_RC, 2'h2);
    send(1'b0, 1'b1, 2'h2, 1'b1);
    send(1'b0, 1'b0, 2'h0, 1'b0);
    prog(irx_pkg::IRX_CMD_FIR, 2'h1);
    @(posedge ref_clk);
    dual_input <= 1'b1;
    send(1'b1, 1'b0, 2'h2, 1'b1);
    send(1'b0, 1'b1, 2'h1, 1'b1);
    send(1'b1, 1'b1, 2'h2, 1'b1);
    send(1'b0, 1'b0, 2'h0, 1'b0);
    t_shut();
    t_supply();
    chk("pin timing", 2'h0, {1'b0, viol});
    close_out();
  end
endmodule
`default_nettype wire
